// File: shared/bit_flag_pkg.sv
// Purpose: Shared constants and types of the bit and flag execution unit.
// Assumes: An 8-bit working register and an 8-bit status register.
// Notes:   Flag positions follow the usual status register layout.

// =============================================================
// Package
package bit_flag_pkg;

  localparam int DATA_W = 8;
  localparam int IDX_W  = 3;

  // Status register bit positions.
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] DATA_RST   = 8'h00;
  localparam logic [4:0] IO_ADDR_RST = 5'h00;

  // Cycle counts of the multi-cycle instructions.
  localparam int IO_CYCLES    = 2;
  localparam int SLEEP_CYCLES = 3;
  localparam logic [1:0] SLEEP_CNT_LOAD = 2'(SLEEP_CYCLES - 2);
  localparam logic [1:0] CNT_RST        = 2'h0;

  typedef enum logic [3:0] {
    no_op,
    io_bit_set_op,
    io_bit_clear_op,
    logical_left_shift_op,
    logical_right_shift_op,
    rotate_left_carry_op,
    rotate_right_carry_op,
    arith_right_shift_op,
    nibble_swap_op,
    flag_index_set_op,
    flag_index_clear_op,
    bit_to_copy_flag_op,
    copy_flag_to_bit_op,
    sleep_op,
    watchdog_restart_op
  } op_e;

  typedef enum logic [1:0] {
    st_idle,
    st_io_rmw,
    st_sleep
  } state_e;

  // One-hot mask for a bit index, shared by I/O, flag and copy operations.
  function automatic logic [7:0] bit_mask(input logic [2:0] idx);
    bit_mask = 8'h01 << idx;
  endfunction : bit_mask

endpackage : bit_flag_pkg

// File: src/bit_flag_exec.sv
// Purpose: Executes the bit, shift, flag, sleep and watchdog instructions.
// Assumes: I/O read data is valid in the cycle io_rd_en is high.
// Notes:   Status register lives here; other units see it on status_register.
//
// Function
// RULE1 - Setting an I/O bit takes two cycles and touches no other bit or flag.
// RULE2 - Clearing an I/O bit takes two cycles and touches no other bit or flag.
// RULE3 - Left shift moves bits up, loads zero in bit 0, in one cycle, updating Z C N V.
// RULE4 - Right shift moves bits down, loads zero in bit 7, in one cycle, updating Z C N V.
// RULE5 - Rotate left puts carry in bit 0 and bit 7 in carry, in one cycle, updating Z C N V.
// RULE6 - Rotate right puts carry in bit 7 and bit 0 in carry, in one cycle, updating Z C N V.
// RULE7 - Arithmetic right shift keeps bit 7, in one cycle, updating Z C N V.
// RULE8 - Nibble exchange swaps the halves in one cycle with no flag change.
// RULE9 - Single-cycle set or clear of C, N, Z, I, S or V changes only that flag.
// RULE10 - Single-cycle set or clear of T or H changes only that flag.
// RULE11 - Bit store copies a register bit into T in one cycle, no other flag.
// RULE12 - Bit load writes T into a register bit in one cycle, no flag change.
// RULE13 - Sleep occupies three cycles and alters no flag.
// RULE14 - Watchdog restart takes one cycle, signals the watchdog, alters no flag.
// RULE15 - No-operation takes one cycle and changes nothing.

`timescale 1ns/10ps
`default_nettype none

// =============================================================
// Execution unit
module bit_flag_exec (
  input  wire logic               sys_clk,
  input  wire logic               resetn,
  input  wire logic               clk_en,
  input  wire logic               op_valid,
  input  wire bit_flag_pkg::op_e  op_code,
  input  wire logic [7:0]         reg_data,
  input  wire logic [2:0]         bit_sel,
  input  wire logic [2:0]         flag_sel,
  input  wire logic [4:0]         io_addr,
  input  wire logic [7:0]         io_rdata,
  output logic                    op_ready,
  output logic                    done,
  output logic                    reg_wr_en,
  output logic [7:0]              reg_wr_data,
  output logic                    io_rd_en,
  output logic [4:0]              io_addr_out,
  output logic                    io_wr_en,
  output logic [7:0]              io_wr_data,
  output logic [7:0]              status_register,
  output logic                    watchdog_restart,
  output logic                    sleep_req
);
  import bit_flag_pkg::*;

  state_e      state_r;
  logic [1:0]  cnt_r;
  logic        accept;
  logic        io_set_r;
  logic [2:0]  io_bit_r;
  logic [4:0]  io_addr_r;
  logic        done_r;
  logic        reg_wr_en_r;
  logic [7:0]  reg_wr_data_r;
  logic        io_wr_en_r;
  logic [7:0]  io_wr_data_r;
  logic [7:0]  status_r;
  logic        wdt_r;
  logic        sleep_r;
  logic [7:0]  shift_q;
  logic        sh_c;
  logic        sh_z;
  logic        sh_n;
  logic        sh_v;
  logic        sh_active;
  logic        sleep_last;

  // =============================================================
  // Datapath
  shift_unit u_shift (
    .op       (op_code),
    .din      (reg_data),
    .carry_in (status_r[FLAG_C]),
    .dout     (shift_q),
    .c_out    (sh_c),
    .z_out    (sh_z),
    .n_out    (sh_n),
    .v_out    (sh_v),
    .is_shift (sh_active)
  );

  // =============================================================
  // Sequencer
  // Only idle takes a new instruction, so multi-cycle operations stall the decoder.
  assign op_ready   = (state_r == st_idle);
  assign accept     = op_valid & op_ready;
  assign io_rd_en   = (state_r == st_io_rmw);
  assign sleep_last = (state_r == st_sleep) && (cnt_r == CNT_RST);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= st_idle;
      cnt_r   <= CNT_RST;
    end else if (clk_en) begin
      unique case (state_r)
        st_idle: begin
          // RULE1 - second cycle follows.
          // RULE2 - second cycle follows.
          if (accept && op_code inside {io_bit_set_op, io_bit_clear_op}) begin
            state_r <= st_io_rmw;
          // RULE13 - three-cycle occupancy.
          end else if (accept && op_code == sleep_op) begin
            state_r <= st_sleep;
            cnt_r   <= SLEEP_CNT_LOAD;
          end
        end
        st_io_rmw: begin
          state_r <= st_idle;
        end
        st_sleep: begin
          if (cnt_r == CNT_RST) begin
            state_r <= st_idle;
          end else begin
            cnt_r <= cnt_r - 2'h1;
          end
        end
      endcase
    end
  end

  // =============================================================
  // I/O read-modify-write
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      io_set_r  <= 1'b0;
      io_bit_r  <= 3'h0;
      io_addr_r <= IO_ADDR_RST;
    end else if (clk_en && accept) begin
      io_set_r  <= (op_code == io_bit_set_op);
      io_bit_r  <= bit_sel;
      io_addr_r <= io_addr;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      io_wr_en_r   <= 1'b0;
      io_wr_data_r <= DATA_RST;
    end else if (clk_en) begin
      io_wr_en_r <= io_rd_en;
      if (io_rd_en) begin
        // RULE1 - only the addressed bit set.
        // RULE2 - only the addressed bit cleared.
        io_wr_data_r <= io_set_r ? (io_rdata | bit_mask(io_bit_r))
                                 : (io_rdata & ~bit_mask(io_bit_r));
      end
    end
  end

  // =============================================================
  // Working register write-back
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reg_wr_en_r   <= 1'b0;
      reg_wr_data_r <= DATA_RST;
    end else if (clk_en) begin
      reg_wr_en_r <= 1'b0;
      if (accept && (sh_active || op_code == nibble_swap_op)) begin
        reg_wr_en_r   <= 1'b1;
        reg_wr_data_r <= shift_q;
      // RULE12 - flag T into the bit.
      end else if (accept && op_code == copy_flag_to_bit_op) begin
        reg_wr_en_r   <= 1'b1;
        reg_wr_data_r <= status_r[FLAG_T] ? (reg_data | bit_mask(bit_sel))
                                          : (reg_data & ~bit_mask(bit_sel));
      end
    end
  end

  // =============================================================
  // Status register
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      status_r <= STATUS_RST;
    end else if (clk_en && accept) begin
      // RULE3 - shift flags Z C N V.
      if (sh_active) begin
        status_r[FLAG_C] <= sh_c;
        status_r[FLAG_Z] <= sh_z;
        status_r[FLAG_N] <= sh_n;
        status_r[FLAG_V] <= sh_v;
      end
      // RULE9 - named flag set.
      // RULE10 - T and H alike.
      if (op_code == flag_index_set_op) begin
        status_r <= status_r | bit_mask(flag_sel);
      end
      // RULE9 - named flag cleared.
      if (op_code == flag_index_clear_op) begin
        status_r <= status_r & ~bit_mask(flag_sel);
      end
      // RULE11 - register bit into T.
      if (op_code == bit_to_copy_flag_op) begin
        status_r[FLAG_T] <= reg_data[bit_sel];
      end
    end
  end

  // =============================================================
  // Completion and side signals
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      done_r  <= 1'b0;
      wdt_r   <= 1'b0;
      sleep_r <= 1'b0;
    end else if (clk_en) begin
      // RULE15 - no-operation completes in one cycle.
      done_r  <= (accept && !(op_code inside {io_bit_set_op, io_bit_clear_op, sleep_op}))
                 || io_rd_en || sleep_last;
      // RULE14 - single-cycle restart pulse.
      wdt_r   <= accept && (op_code == watchdog_restart_op);
      // RULE13 - sleep request after third cycle.
      sleep_r <= sleep_last;
    end
  end

  assign done             = done_r;
  assign reg_wr_en        = reg_wr_en_r;
  assign reg_wr_data      = reg_wr_data_r;
  assign io_addr_out      = io_addr_r;
  assign io_wr_en         = io_wr_en_r;
  assign io_wr_data       = io_wr_data_r;
  assign status_register  = status_r;
  assign watchdog_restart = wdt_r;
  assign sleep_req        = sleep_r;

  // =============================================================
  // Checks
  // Checks sample only enabled edges, since a low enable freezes the unit.
  default clocking cb @(posedge sys_clk iff clk_en); endclocking
  default disable iff (!resetn);

  sequence io_start_s;
    accept && op_code inside {io_bit_set_op, io_bit_clear_op};
  endsequence

  sequence io_finish_s;
    io_rd_en && !done_r ##1 io_wr_en_r && done_r && op_ready;
  endsequence

  // RULE1 - two-cycle set.
  chk_io_set_bit: assert property (accept && op_code == io_bit_set_op |=> io_finish_s // RULE1
    ##0 (io_wr_data_r == ($past(io_rdata) | bit_mask($past(bit_sel, 2))))
    ##0 (status_r == $past(status_r, 2)))
    else $error("I/O bit set wrong.");

  // RULE2 - two-cycle clear.
  chk_io_clear_bit: assert property (accept && op_code == io_bit_clear_op |=> io_finish_s // RULE2
    ##0 (io_wr_data_r == ($past(io_rdata) & ~bit_mask($past(bit_sel, 2))))
    ##0 (status_r == $past(status_r, 2)))
    else $error("I/O bit clear wrong.");

  // RULE1 - no overlap while busy.
  chk_io_busy_gate: assert property (io_start_s |=> !op_ready ##1 op_ready) // RULE1
    else $error("I/O operation did not hold the decoder.");

  // RULE3 - left shift result.
  chk_lsl_result: assert property (accept && op_code == logical_left_shift_op |=> // RULE3
    reg_wr_en_r && done_r && reg_wr_data_r == {$past(reg_data[6:0]), 1'b0}
    && status_r[FLAG_C] == $past(reg_data[7]))
    else $error("Left shift wrong.");

  // RULE4 - right shift result.
  chk_lsr_result: assert property (accept && op_code == logical_right_shift_op |=> // RULE4
    reg_wr_data_r == {1'b0, $past(reg_data[7:1])} && !status_r[FLAG_N]
    && status_r[FLAG_C] == $past(reg_data[0]))
    else $error("Right shift wrong.");

  // RULE5 - rotate left result.
  chk_rol_result: assert property (accept && op_code == rotate_left_carry_op |=> // RULE5
    reg_wr_data_r == {$past(reg_data[6:0]), $past(status_r[FLAG_C])}
    && status_r[FLAG_V] == (status_r[FLAG_N] ^ status_r[FLAG_C]))
    else $error("Rotate left wrong.");

  // RULE6 - rotate right result.
  chk_ror_result: assert property (accept && op_code == rotate_right_carry_op |=> // RULE6
    reg_wr_data_r == {$past(status_r[FLAG_C]), $past(reg_data[7:1])}
    && status_r[FLAG_Z] == (reg_wr_data_r == 8'h00))
    else $error("Rotate right wrong.");

  // RULE7 - sign kept.
  chk_asr_result: assert property (accept && op_code == arith_right_shift_op |=> // RULE7
    reg_wr_data_r == {$past(reg_data[7]), $past(reg_data[7:1])})
    else $error("Arithmetic shift wrong.");

  // RULE8 - swap keeps flags.
  chk_swap_flags: assert property (accept && op_code == nibble_swap_op |=> // RULE8
    reg_wr_data_r == {$past(reg_data[3:0]), $past(reg_data[7:4])}
    && $stable(status_r))
    else $error("Nibble exchange wrong.");

  // RULE9 - single flag set.
  chk_flag_set: assert property (accept && op_code == flag_index_set_op |=> // RULE9
    status_r == ($past(status_r) | bit_mask($past(flag_sel))) && !reg_wr_en_r)
    else $error("Flag set wrong.");

  // RULE10 - single flag clear.
  chk_flag_clear: assert property (accept && op_code == flag_index_clear_op |=> // RULE10
    status_r == ($past(status_r) & ~bit_mask($past(flag_sel))))
    else $error("Flag clear wrong.");

  // RULE11 - bit store into T.
  chk_bit_store: assert property (accept && op_code == bit_to_copy_flag_op |=> // RULE11
    status_r[FLAG_T] == $past(reg_data[bit_sel])
    && {status_r[FLAG_I], status_r[5:0]} == $past({status_r[FLAG_I], status_r[5:0]}))
    else $error("Bit store wrong.");

  // RULE12 - bit load from T.
  chk_bit_load: assert property (accept && op_code == copy_flag_to_bit_op |=> // RULE12
    reg_wr_en_r && reg_wr_data_r[$past(bit_sel)] == $past(status_r[FLAG_T])
    && $stable(status_r))
    else $error("Bit load wrong.");

  // RULE13 - three-cycle sleep.
  chk_sleep_three: assert property (accept && op_code == sleep_op |=> // RULE13
    (!op_ready && !done_r && $stable(status_r)) [*2]
    ##1 (sleep_r && done_r && op_ready))
    else $error("Sleep timing wrong.");

  // RULE14 - watchdog pulse, high again only for a back-to-back restart.
  chk_wdt_pulse: assert property (accept && op_code == watchdog_restart_op |=> // RULE14
    wdt_r && done_r && $stable(status_r)
    ##1 (wdt_r == $past(accept && op_code == watchdog_restart_op)))
    else $error("Watchdog restart wrong.");

  // RULE15 - no-operation is inert.
  chk_nop_inert: assert property (accept && op_code == no_op |=> // RULE15
    done_r && !reg_wr_en_r && !io_wr_en_r && $stable(status_r))
    else $error("No-operation changed state.");

endmodule : bit_flag_exec

`default_nettype wire

// File: src/shift_unit.sv
// Purpose: Combinational shift, rotate and nibble exchange datapath.
// Assumes: Carry input is the current carry flag of the status register.
// Notes:   Flag outputs are meaningful only for the shift and rotate codes.

`timescale 1ns/10ps
`default_nettype none

// =============================================================
// Shift unit
module shift_unit (
  input  wire bit_flag_pkg::op_e  op,
  input  wire logic [7:0]         din,
  input  wire logic               carry_in,
  output logic [7:0]              dout,
  output logic                    c_out,
  output logic                    z_out,
  output logic                    n_out,
  output logic                    v_out,
  output logic                    is_shift
);
  import bit_flag_pkg::*;

  always_comb begin
    dout     = din;
    c_out    = carry_in;
    is_shift = 1'b1;
    unique case (op)
      // RULE3 - zero into bit 0.
      logical_left_shift_op: begin
        dout  = {din[6:0], 1'b0};
        c_out = din[7];
      end
      // RULE4 - zero into bit 7.
      logical_right_shift_op: begin
        dout  = {1'b0, din[7:1]};
        c_out = din[0];
      end
      // RULE5 - carry into bit 0.
      rotate_left_carry_op: begin
        dout  = {din[6:0], carry_in};
        c_out = din[7];
      end
      // RULE6 - carry into bit 7.
      rotate_right_carry_op: begin
        dout  = {carry_in, din[7:1]};
        c_out = din[0];
      end
      // RULE7 - sign bit kept.
      arith_right_shift_op: begin
        dout  = {din[7], din[7:1]};
        c_out = din[0];
      end
      // RULE8 - nibble exchange.
      nibble_swap_op: begin
        dout     = {din[3:0], din[7:4]};
        is_shift = 1'b0;
      end
      default: begin
        is_shift = 1'b0;
      end
    endcase
  end

  // The overflow of a one-place shift is the sign change, N xor C.
  assign z_out = (dout == 8'h00);
  assign n_out = dout[7];
  assign v_out = dout[7] ^ c_out;

endmodule : shift_unit

`default_nettype wire

// File: testbench/bit_flag_execution_unit_tb_top.sv
// Purpose: Self-checking bench for the bit and flag execution unit.
// Assumes: Inputs change on the falling edge and the design samples on the rising edge.
// Notes:   Expected results come from a small reference model of the status flags kept here.

`timescale 1ns/10ps
`default_nettype none

// =============================================================
// Bench
module bit_flag_execution_unit_tb_top;
  import bit_flag_pkg::*;

  logic       sys_clk          = 1'b0;
  logic       resetn           = 1'b0;
  logic       clk_en           = 1'b1;
  logic       op_valid         = 1'b0;
  op_e        op_code          = no_op;
  logic [7:0] reg_data         = 8'h00;
  logic [2:0] bit_sel          = 3'h0;
  logic [2:0] flag_sel         = 3'h0;
  logic [4:0] io_addr          = 5'h00;
  logic [7:0] io_rdata         = 8'h00;
  logic       op_ready;
  logic       done;
  logic       reg_wr_en;
  logic       io_rd_en;
  logic       io_wr_en;
  logic       watchdog_restart;
  logic       sleep_req;
  logic [7:0] reg_wr_data;
  logic [7:0] io_wr_data;
  logic [7:0] status_register;
  logic [4:0] io_addr_out;
  logic [7:0] status_register_exp         = 8'h00;
  int         miscompares      = 0;
  int         n_checks         = 0;
  op_e        shift_ops [6]    = '{logical_left_shift_op, logical_right_shift_op,
                                   rotate_left_carry_op, rotate_right_carry_op,
                                   arith_right_shift_op, nibble_swap_op};
  logic [7:0] vals [6]         = '{8'h80, 8'h01, 8'h00, 8'hA5, 8'h7F, 8'hC3};

  always #4 sys_clk = ~sys_clk;

  bit_flag_exec bit_flag_exec_inst (
    .sys_clk          (sys_clk),
    .resetn           (resetn),
    .clk_en           (clk_en),
    .op_valid         (op_valid),
    .op_code          (op_code),
    .reg_data         (reg_data),
    .bit_sel          (bit_sel),
    .flag_sel         (flag_sel),
    .io_addr          (io_addr),
    .io_rdata         (io_rdata),
    .op_ready         (op_ready),
    .done             (done),
    .reg_wr_en        (reg_wr_en),
    .reg_wr_data      (reg_wr_data),
    .io_rd_en         (io_rd_en),
    .io_addr_out      (io_addr_out),
    .io_wr_en         (io_wr_en),
    .io_wr_data       (io_wr_data),
    .status_register  (status_register),
    .watchdog_restart (watchdog_restart),
    .sleep_req        (sleep_req)
  );

  // =============================================================
  // Tasks
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  // Offers one instruction at a falling edge and checks everything at its done cycle.
  // A single-cycle op leaves op_valid high so that the next call can follow back to back.
  task automatic run_op(input op_e op, input logic [7:0] d, input logic [2:0] b,
                        input logic [2:0] f, input logic [7:0] io_d, input int stall);
    int         cyc;
    int         n;
    logic       rw;
    logic       iow;
    logic       c;
    logic [7:0] res;
    logic [7:0] iod;
    op_valid = 1'b1;
    op_code  = op;
    reg_data = d;
    bit_sel  = b;
    flag_sel = f;
    io_addr  = {2'h3, b};
    io_rdata = io_d;
    chk("op_ready", 1'b1, op_ready);
    // Frozen edges must not move the flags.
    if (stall > 0) begin
      clk_en = 1'b0;
      repeat (stall) begin
        @(negedge sys_clk);
        chk("frozen status", status_register_exp, status_register);
      end
      clk_en = 1'b1;
    end
    cyc = (op == sleep_op) ? 3 : (op inside {io_bit_set_op, io_bit_clear_op}) ? 2 : 1;
    rw  = op inside {[logical_left_shift_op:nibble_swap_op], copy_flag_to_bit_op};
    iow = op inside {io_bit_set_op, io_bit_clear_op};
    res = d;
    iod = io_d;
    c   = status_register_exp[FLAG_C];
    case (op)
      io_bit_set_op:          iod = io_d | (8'h01 << b);
      io_bit_clear_op:        iod = io_d & ~(8'h01 << b);
      logical_left_shift_op:  {c, res} = {d, 1'b0};
      logical_right_shift_op: {res, c} = {1'b0, d};
      rotate_left_carry_op:   {c, res} = {d, status_register_exp[FLAG_C]};
      rotate_right_carry_op:  {res, c} = {status_register_exp[FLAG_C], d};
      arith_right_shift_op:   {res, c} = {d[7], d};
      nibble_swap_op:         res = {d[3:0], d[7:4]};
      flag_index_set_op:      status_register_exp[f] = 1'b1;
      flag_index_clear_op:    status_register_exp[f] = 1'b0;
      bit_to_copy_flag_op:    status_register_exp[FLAG_T] = d[b];
      copy_flag_to_bit_op:    res[b] = status_register_exp[FLAG_T];
      default: ;
    endcase
    // Shifts own V N Z C only; V is N xor C of the result.
    if (rw && op != nibble_swap_op && op != copy_flag_to_bit_op) begin
      status_register_exp[3:0] = {res[7] ^ c, res[7], res == 8'h00, c};
    end
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
      if (n == 1 && cyc > 1) begin
        chk("io_rd_en", iow, io_rd_en);
        chk("io_addr_out", {3'h0, io_addr}, {3'h0, io_addr_out});
        // A request while busy must be ignored, not queued.
        if (op == sleep_op) begin
          op_code = watchdog_restart_op;
        end else begin
          op_valid = 1'b0;
        end
      end
      if (n == 2 && op == sleep_op) begin
        op_valid = 1'b0;
      end
      if (n < cyc) begin
        chk("op_ready busy", 1'b0, op_ready);
      end
    end while (done !== 1'b1 && n < 8);
    if (n >= 8) begin
      miscompares++;
      $display("Error done expected 1 seen %b", done);
      report_and_stop();
    end
    chk("cycles", 8'(cyc), 8'(n));
    chk("reg_wr_en", rw, reg_wr_en);
    if (rw) begin
      chk("reg_wr_data", res, reg_wr_data);
    end
    chk("io_wr_en", iow, io_wr_en);
    if (iow) begin
      chk("io_wr_data", iod, io_wr_data);
    end
    chk("watchdog_restart", op == watchdog_restart_op, watchdog_restart);
    chk("sleep_req", op == sleep_op, sleep_req);
    chk("status_register", status_register_exp, status_register);
  endtask : run_op

  // =============================================================
  // Sequence
  initial begin
    repeat (8) @(negedge sys_clk);
    resetn = 1'b1;
    @(negedge sys_clk);
    chk("status reset", STATUS_RST, status_register);
    run_op(no_op, 8'hFF, 3'h7, 3'h7, 8'hFF, 0);
    for (int i = 0; i < 8; i++) begin
      run_op(io_bit_set_op, 8'h00, 3'(i), 3'h0, 8'h5A ^ 8'(i), 0);
      run_op(io_bit_clear_op, 8'h00, 3'(i), 3'h0, 8'hA5 | 8'(i), 0);
      run_op(flag_index_set_op, 8'h00, 3'h0, 3'(i), 8'h00, 0);
    end
    run_op(sleep_op, 8'h00, 3'h1, 3'h0, 8'h00, 0);
    run_op(watchdog_restart_op, 8'h00, 3'h0, 3'h0, 8'h00, 0);
    foreach (vals[i]) begin
      foreach (shift_ops[k]) begin
        run_op(shift_ops[k], vals[i], 3'h0, 3'h0, 8'h00, (i == 3 && k == 0) ? 2 : 0);
      end
    end
    for (int i = 0; i < 8; i++) begin
      run_op(flag_index_clear_op, 8'h00, 3'h0, 3'(i), 8'h00, 0);
      run_op(bit_to_copy_flag_op, 8'h01 << i, 3'(i), 3'h0, 8'h00, 0);
      run_op(copy_flag_to_bit_op, 8'h00, 3'(7 - i), 3'h0, 8'h00, 0);
      run_op(bit_to_copy_flag_op, ~(8'h01 << i), 3'(i), 3'h0, 8'h00, 0);
      run_op(copy_flag_to_bit_op, 8'hFF, 3'(7 - i), 3'h0, 8'h00, 0);
    end
    run_op(sleep_op, 8'h00, 3'h2, 3'h0, 8'h00, 0);
    run_op(watchdog_restart_op, 8'h00, 3'h0, 3'h0, 8'h00, 0);
    run_op(watchdog_restart_op, 8'h00, 3'h0, 3'h0, 8'h00, 0);
    run_op(no_op, 8'h3C, 3'h5, 3'h6, 8'h3C, 0);
    op_valid = 1'b0;
    @(negedge sys_clk);
    report_and_stop();
  end

endmodule : bit_flag_execution_unit_tb_top

`default_nettype wire
